// ---- common/gpq_regs.vh ----
`ifndef GPQ_REGS_VH
`define GPQ_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GPQ_LEFT_POS_OFF      32'h0000_0000
`define GPQ_RIGHT_POS_OFF     32'h0000_0004
`define GPQ_STATUS_OFF        32'h0000_0008
`define GPQ_PRESET_OFF        32'h0000_000C

// ****************************************************************
// Reset values
// ****************************************************************
`define GPQ_COUNT_RESET       8'h00
`define GPQ_PRESET_RESET      16'h0000
`define GPQ_WORD_ZERO         32'h0000_0000

// ****************************************************************
// Field positions
// ****************************************************************
`define GPQ_POS_WIDTH         16
`define GPQ_PRESET_V_HI       15
`define GPQ_PRESET_V_LO       10
`define GPQ_PRESET_H_HI       7
`define GPQ_PRESET_H_LO       2
`define GPQ_STAT_BTN_LO       0
`define GPQ_STAT_SKIP_LO      8
`define GPQ_STAT_SKIP_HI      11

// ****************************************************************
// Bus encodings
// ****************************************************************
`define GPQ_HTRANS_NONSEQ     2'h2
`define GPQ_HTRANS_SEQ        2'h3
`define GPQ_HSIZE_WORD        3'h2
`define GPQ_HRESP_OKAY        1'h0

// ****************************************************************
// Quadrature step codes (new minus old, modulo four)
// ****************************************************************
`define GPQ_STEP_UP           2'h1
`define GPQ_STEP_SKIP         2'h2
`define GPQ_STEP_DOWN         2'h3
`define GPQ_LOW_MAX           2'h3
`define GPQ_LOW_MIN           2'h0
`define GPQ_UPPER_ONE         6'h01

// ****************************************************************
// Settling after reset
// ****************************************************************
`define GPQ_SETTLE_RESET      3'h0
`define GPQ_SETTLE_MSB        2

`endif

// ---- hw/gpq_axis.v ----
`timescale 1ns/100ps
`include "gpq_regs.vh"
`default_nettype none

// ****************************************************************
// One 8-bit quadrature axis counter
// ****************************************************************
// The low two bits always mirror the pins: bit 1 is the phase pin,
// bit 0 is pulse xor phase. A gray-code walk on the pins is then a
// binary walk on these bits, and only the upper six bits need an
// adder. The same bits serve joystick switches with no mode setting.
// Steps and skips only count while count_en is high, so the first
// real pin code after reset is not taken for motion.
module gpq_axis
(
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       pulse_in,
    input  wire       phase_in,
    input  wire       count_en,
    input  wire       load,
    input  wire [5:0] load_value,
    output reg  [7:0] count,
    output reg        skip
);

    wire [1:0] next_low;
    wire [1:0] step;

    // Pin code and its distance from the stored code
    assign next_low = {phase_in, pulse_in ^ phase_in};
    assign step     = next_low - count[1:0];

    // Carry into the upper bits on wrap; count wraps modulo 256
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= `GPQ_COUNT_RESET;
            skip  <= 1'b0;
        end
        else
        begin
            count[1:0] <= next_low;
            skip       <= count_en && (step == `GPQ_STEP_SKIP);
            if (load)
                count[7:2] <= load_value;
            else if (count_en && step == `GPQ_STEP_UP &&
                     next_low == `GPQ_LOW_MIN)
                count[7:2] <= count[7:2] + `GPQ_UPPER_ONE;
            else if (count_en && step == `GPQ_STEP_DOWN &&
                     next_low == `GPQ_LOW_MAX)
                count[7:2] <= count[7:2] - `GPQ_UPPER_ONE;
        end
    end

endmodule

`default_nettype wire

// ---- hw/gpq_sync.v ----
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for the connector pins
// ****************************************************************
module gpq_sync
(
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [7:0] pins_in,
    output reg  [7:0] pins_sync
);

    reg [7:0] meta;

    // First stage feeds only the second stage
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta      <= 8'h00;
            pins_sync <= 8'h00;
        end
        else
        begin
            meta      <= pins_in;
            pins_sync <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- hw/gpq_top.v ----
// Contract
// - Each port has a 16-bit position word: vertical high, horizontal low.
// - Vertical count falls on upward steps and rises on downward steps.
// - Horizontal count rises on rightward steps and falls on leftward.
// - Joystick forward is bit 9 xor bit 8; left is bit 9.
// - Joystick back is bit 1 xor bit 0; right is bit 1.
// - Joystick and mouse share pins and counters, with no mode setting.
// - Counts are always valid; a read at any time is coherent.
// - Right connector feeds position word 1, left connector word 0.
// - Left and right inputs double as buttons for proportional use.
// - Each 8-bit count wraps modulo 256.
`timescale 1ns/100ps
`include "gpq_regs.vh"
`default_nettype none

module gpq_top
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        left_vertical_pulse_in,
    input  wire        left_vertical_phase_in,
    input  wire        left_horizontal_pulse_in,
    input  wire        left_horizontal_phase_in,
    input  wire        right_vertical_pulse_in,
    input  wire        right_vertical_phase_in,
    input  wire        right_horizontal_pulse_in,
    input  wire        right_horizontal_phase_in
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire [7:0]  pins_raw;
    wire [7:0]  pins_sync;
    wire [7:0]  left_vertical_count;
    wire [7:0]  left_horizontal_count;
    wire [7:0]  right_vertical_count;
    wire [7:0]  right_horizontal_count;
    wire [3:0]  skip_event;
    wire [15:0] left_port_position;
    wire [15:0] right_port_position;
    wire [3:0]  button_view;
    wire        addr_phase;
    wire        write_phase;
    wire [3:0]  skip_clear;
    reg  [3:0]  next_skip_flags;
    reg  [3:0]  skip_flags;
    reg  [15:0] counter_preset;
    reg         preset_load;
    reg         dphase_write;
    reg  [31:0] dphase_addr;
    reg  [31:0] next_hrdata;
    reg  [`GPQ_SETTLE_MSB:0] settle;
    wire        counting;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Word hit on one register, full address compared
    function hit;
        input [31:0] addr;
        input [31:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // Active-high view of the two direction switches of a port
    function [1:0] buttons;
        input [15:0] position;
        begin
            buttons = {~position[9], ~position[1]};
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************

    // Connector pins are asynchronous to hclk
    assign pins_raw = {right_horizontal_phase_in,
                       right_horizontal_pulse_in,
                       right_vertical_phase_in,
                       right_vertical_pulse_in,
                       left_horizontal_phase_in,
                       left_horizontal_pulse_in,
                       left_vertical_phase_in,
                       left_vertical_pulse_in};

    gpq_sync u_sync
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pins_in   (pins_raw),
        .pins_sync (pins_sync)
    );

    // ****************************************************************
    // Settling after reset
    // ****************************************************************
    // The synchroniser leaves reset showing every pin low and turns
    // into the true pin levels two edges later. A device resting on
    // any code but zero would then look like a step or a skip. The
    // low count bits follow the pins from the start; only the upper
    // bits and the skip flags wait. Motion in those edges is lost.

    // Shift in ones until the synchronised pins are trustworthy
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            settle <= `GPQ_SETTLE_RESET;
        else
            settle <= {settle[`GPQ_SETTLE_MSB-1:0], 1'b1};
    end

    // Counting starts one edge after the pins first show up
    assign counting = settle[`GPQ_SETTLE_MSB];

    // ****************************************************************
    // Axis counters
    // ****************************************************************
    // Direction follows the pin order: a device moving down or right
    // walks its code forward, up or left walks it backward.

    // Left connector, vertical pair
    gpq_axis u_left_vertical
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pulse_in   (pins_sync[0]),
        .count_en   (counting),
        .phase_in   (pins_sync[1]),
        .load       (preset_load),
        .load_value (counter_preset[`GPQ_PRESET_V_HI:`GPQ_PRESET_V_LO]),
        .count      (left_vertical_count),
        .skip       (skip_event[0])
    );

    // Left connector, horizontal pair
    gpq_axis u_left_horizontal
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pulse_in   (pins_sync[2]),
        .count_en   (counting),
        .phase_in   (pins_sync[3]),
        .load       (preset_load),
        .load_value (counter_preset[`GPQ_PRESET_H_HI:`GPQ_PRESET_H_LO]),
        .count      (left_horizontal_count),
        .skip       (skip_event[1])
    );

    // Right connector, vertical pair
    gpq_axis u_right_vertical
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pulse_in   (pins_sync[4]),
        .count_en   (counting),
        .phase_in   (pins_sync[5]),
        .load       (preset_load),
        .load_value (counter_preset[`GPQ_PRESET_V_HI:`GPQ_PRESET_V_LO]),
        .count      (right_vertical_count),
        .skip       (skip_event[2])
    );

    // Right connector, horizontal pair
    gpq_axis u_right_horizontal
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pulse_in   (pins_sync[6]),
        .count_en   (counting),
        .phase_in   (pins_sync[7]),
        .load       (preset_load),
        .load_value (counter_preset[`GPQ_PRESET_H_HI:`GPQ_PRESET_H_LO]),
        .count      (right_horizontal_count),
        .skip       (skip_event[3])
    );

    // ****************************************************************
    // Position words
    // ****************************************************************

    // Vertical in the high byte, horizontal in the low byte
    assign left_port_position  = {left_vertical_count,
                                  left_horizontal_count};
    assign right_port_position = {right_vertical_count,
                                  right_horizontal_count};

    // Button view: left port in bits 1:0, right port in bits 3:2
    assign button_view = {buttons(right_port_position),
                          buttons(left_port_position)};

    // ****************************************************************
    // Bus slave: address phase
    // ****************************************************************
    // Zero wait states, so every transfer ends in one data phase and
    // the only answer is OKAY. Only whole-word transfers act.

    assign hreadyout = 1'b1;
    assign hresp     = `GPQ_HRESP_OKAY;

    // A valid word transfer aimed at this slave
    assign addr_phase = hsel && hready && hsize == `GPQ_HSIZE_WORD &&
                        (htrans == `GPQ_HTRANS_NONSEQ ||
                         htrans == `GPQ_HTRANS_SEQ);

    // Read mux; counters are read as they stand, never stale
    always @*
    begin
        next_hrdata = `GPQ_WORD_ZERO;
        if (hit(haddr, `GPQ_LEFT_POS_OFF))
            next_hrdata = {16'h0000, left_port_position};
        else if (hit(haddr, `GPQ_RIGHT_POS_OFF))
            next_hrdata = {16'h0000, right_port_position};
        else if (hit(haddr, `GPQ_STATUS_OFF))
            next_hrdata = {20'h0_0000, skip_flags, 4'h0, button_view};
        else if (hit(haddr, `GPQ_PRESET_OFF))
            next_hrdata = {16'h0000, counter_preset};
    end

    // Capture read data and the write target for the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata       <= `GPQ_WORD_ZERO;
            dphase_write <= 1'b0;
            dphase_addr  <= `GPQ_WORD_ZERO;
        end
        else
        begin
            dphase_write <= addr_phase && hwrite;
            if (addr_phase)
                dphase_addr <= haddr;
            if (addr_phase && !hwrite)
                hrdata <= next_hrdata;
        end
    end

    // ****************************************************************
    // Bus slave: data phase writes
    // ****************************************************************

    // Write data stands in the cycle after the address phase
    assign write_phase = dphase_write;

    // Preset register; a write also loads all upper count bits once
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            counter_preset <= `GPQ_PRESET_RESET;
            preset_load    <= 1'b0;
        end
        else
        begin
            preset_load <= 1'b0;
            if (write_phase && hit(dphase_addr, `GPQ_PRESET_OFF))
            begin
                counter_preset <= hwdata[15:0];
                preset_load    <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Skipped-step flags
    // ****************************************************************
    // A two-state jump means the device outran the sampling; the
    // count has lost a step. Write one to clear; a new jump in the
    // clearing cycle keeps the flag set.

    assign skip_clear = (write_phase && hit(dphase_addr, `GPQ_STATUS_OFF))
                        ? hwdata[`GPQ_STAT_SKIP_HI:`GPQ_STAT_SKIP_LO]
                        : 4'h0;

    always @*
    begin
        next_skip_flags = (skip_flags & ~skip_clear) | skip_event;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            skip_flags <= 4'h0;
        else
            skip_flags <= next_skip_flags;
    end

endmodule

`default_nettype wire

// ---- testbench/gpq_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module gpq_chk
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        left_vertical_pulse_in,
    input wire logic        left_vertical_phase_in,
    input wire logic        left_horizontal_pulse_in,
    input wire logic        left_horizontal_phase_in,
    input wire logic        right_vertical_pulse_in,
    input wire logic        right_vertical_phase_in,
    input wire logic        right_horizontal_pulse_in,
    input wire logic        right_horizontal_phase_in
);
    wire       rd = hsel & hready & htrans[1] & (hsize == 3'h2) & !hwrite;
    wire [3:0] lp = {left_vertical_pulse_in, left_vertical_phase_in,
                     left_horizontal_pulse_in, left_horizontal_phase_in};
    wire [3:0] rp = {right_vertical_pulse_in, right_vertical_phase_in,
                     right_horizontal_pulse_in, right_horizontal_phase_in};
    reg  [3:0] lq;
    reg  [3:0] rq;
    reg  [2:0] lc;
    reg  [2:0] rc;

    // Pin quiet time; the two-flop sync and the count register hide changes for three edges
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lq <= 4'h0;
            rq <= 4'h0;
            lc <= 3'h0;
            rc <= 3'h0;
        end
        else
        begin
            lq <= lp;
            rq <= rp;
            lc <= (lp != lq) ? 3'h0 : ((lc == 3'h7) ? lc : lc + 3'h1);
            rc <= (rp != rq) ? 3'h0 : ((rc == 3'h7) ? rc : rc + 3'h1);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ****************************************************************
    // Bus answer
    // ****************************************************************

    // Zero wait states, OKAY only, read data held between reads
    property p_ready;
        hreadyout == 1'b1;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state seen");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("error response");
    property p_hold;
        !rd |=> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved");
    property p_upper;
        rd && (haddr == 32'h0000_0000 || haddr == 32'h0000_0004)
        |=> hrdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper half set");

    // ****************************************************************
    // Low count bits against settled pins
    // ****************************************************************

    // Only once the pins have been quiet longer than the sync delay
    property p_lh;
        rd && haddr == 32'h0000_0000 && lc >= 3'h5 |=> hrdata[1:0] ==
        {$past(lp[0]), $past(lp[1] ^ lp[0])};
    endproperty
    a_lh: assert property (p_lh)
        else $error("left x low bits");
    property p_lv;
        rd && haddr == 32'h0000_0000 && lc >= 3'h5 |=> hrdata[9:8] ==
        {$past(lp[2]), $past(lp[3] ^ lp[2])};
    endproperty
    a_lv: assert property (p_lv)
        else $error("left y low bits");
    property p_rh;
        rd && haddr == 32'h0000_0004 && rc >= 3'h5 |=> hrdata[1:0] ==
        {$past(rp[0]), $past(rp[1] ^ rp[0])};
    endproperty
    a_rh: assert property (p_rh)
        else $error("right x low bits");
    property p_rv;
        rd && haddr == 32'h0000_0004 && rc >= 3'h5 |=> hrdata[9:8] ==
        {$past(rp[2]), $past(rp[3] ^ rp[2])};
    endproperty
    a_rv: assert property (p_rv)
        else $error("right y low bits");
    property p_btn;
        rd && haddr == 32'h0000_0008 && lc >= 3'h5 && rc >= 3'h5 |=>
        hrdata[3:0] ==
        ~{$past(rp[2]), $past(rp[0]), $past(lp[2]), $past(lp[0])};
    endproperty
    a_btn: assert property (p_btn)
        else $error("button bits wrong");
endmodule

// Checker sees the top ports only
bind gpq_top gpq_chk u_chk
(
    .hclk                      (hclk),
    .hresetn                   (hresetn),
    .hsel                      (hsel),
    .haddr                     (haddr),
    .htrans                    (htrans),
    .hwrite                    (hwrite),
    .hsize                     (hsize),
    .hready                    (hready),
    .hreadyout                 (hreadyout),
    .hresp                     (hresp),
    .hrdata                    (hrdata),
    .left_vertical_pulse_in    (left_vertical_pulse_in),
    .left_vertical_phase_in    (left_vertical_phase_in),
    .left_horizontal_pulse_in  (left_horizontal_pulse_in),
    .left_horizontal_phase_in  (left_horizontal_phase_in),
    .right_vertical_pulse_in   (right_vertical_pulse_in),
    .right_vertical_phase_in   (right_vertical_phase_in),
    .right_horizontal_pulse_in (right_horizontal_pulse_in),
    .right_horizontal_phase_in (right_horizontal_phase_in)
);

`default_nettype wire

// ---- testbench/gpq_mouse.sv ----
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Pointing device on one axis
// ****************************************************************
module gpq_mouse
(
    input  wire logic hclk,
    input  wire logic step,
    input  wire logic back,
    input  wire logic jump,
    output logic      pulse,
    output logic      phase
);
    logic [1:0] wheel = 2'h0;

    // Gray walk; a jump breaks it on purpose to provoke a skip
    always @(posedge hclk)
        if (step)
            wheel <= wheel + (jump ? 2'h2 : (back ? 2'h3 : 2'h1));
    assign pulse = wheel[1] ^ wheel[0];
    assign phase = wheel[1];
endmodule

`default_nettype wire

// ---- testbench/gpq_top_tb.sv ----
`timescale 1ns/100ps
`include "gpq_regs.vh"
`default_nettype none

module gpq_top_tb;
    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd, pre;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  st, bk, jp;
    wire         hreadyout, hresp;
    wire  [31:0] hrdata;
    wire  [3:0]  pul, pha;
    integer      err_count, tests_run, i, j, cnt [0:3];

    // Axes: 0 left y, 1 left x, 2 right y, 3 right x
    gpq_top dut
    (
        .hclk                      (hclk),
        .hresetn                   (hresetn),
        .hsel                      (hsel),
        .haddr                     (haddr),
        .htrans                    (htrans),
        .hwrite                    (hwrite),
        .hsize                     (hsize),
        .hwdata                    (hwdata),
        .hready                    (hreadyout),
        .hreadyout                 (hreadyout),
        .hresp                     (hresp),
        .hrdata                    (hrdata),
        .left_vertical_pulse_in    (pul[0]),
        .left_vertical_phase_in    (pha[0]),
        .left_horizontal_pulse_in  (pul[1]),
        .left_horizontal_phase_in  (pha[1]),
        .right_vertical_pulse_in   (pul[2]),
        .right_vertical_phase_in   (pha[2]),
        .right_horizontal_pulse_in (pul[3]),
        .right_horizontal_phase_in (pha[3])
    );
    gpq_mouse mouse [3:0] (.hclk(hclk), .step(st), .back(bk), .jump(jp),
        .pulse(pul), .phase(pha));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task final_report;
        $display("Compares %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input logic [31:0] mask);
        tests_run++;
        if ((got & mask) !== (exp & mask))
        begin
            err_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Single word transfer; entered just after a rising edge
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= `GPQ_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= `GPQ_HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    function automatic logic [31:0] pos(input integer p);
        pos = {16'h0000, cnt[2*p][7:0], cnt[2*p+1][7:0]};
    endfunction

    // Let the sync pipeline settle, then read both words
    task rdpos;
        repeat (6) @(posedge hclk);
        bus(1'b0, `GPQ_LEFT_POS_OFF, 32'h0000_0000);
        chk(rd, pos(0), 32'hFFFF_FFFF);
        bus(1'b0, `GPQ_RIGHT_POS_OFF, 32'h0000_0000);
        chk(rd, pos(1), 32'hFFFF_FFFF);
        chk({28'h0, rd[9] ^ rd[8], rd[9], rd[1] ^ rd[0], rd[1]},
            {28'h0, pul[2], pha[2], pul[3], pha[3]},
            32'h0000_000F);
    endtask

    // Kind 0 forward, 1 backward, 2 jump of two
    task step(input integer a, input integer k);
        st[a] <= 1'b1;
        bk[a] <= (k == 1);
        jp[a] <= (k == 2);
        @(posedge hclk);
        st <= 4'h0;
        if (k == 2)
            cnt[a] = (cnt[a] & ~3) | ((cnt[a] + 2) & 3);
        else
            cnt[a] = (cnt[a] + (k ? -1 : 1)) & 255;
        repeat (1 + $urandom_range(2)) @(posedge hclk);
    endtask

    initial
    begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        {st, bk, jp} = '0;
        err_count = 0;
        tests_run = 0;
        for (i = 0; i < 4; i++) cnt[i] = 0;
        i = $urandom(32'h36ce6be3);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdpos;
        bus(1'b0, `GPQ_STATUS_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_000F, 32'h0000_0F0F);
        bus(1'b0, `GPQ_PRESET_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0000, 32'h0000_FCFC);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd, 32'h0000_0000, 32'hFFFF_FFFF);
        $display("Test reset values done");
        for (j = 0; j < 400; j++)
        begin
            step($urandom_range(3), $urandom_range(1));
            if (j % 40 == 39) rdpos;
        end
        $display("Test random walk done");
        for (j = 0; j < 300; j++) step(1, 0);
        i = cnt[2] + 5;
        for (j = 0; j < i; j++) step(2, 1);
        rdpos;
        $display("Test wrap done");
        pre = $urandom & 32'h0000_FCFC;
        bus(1'b1, `GPQ_PRESET_OFF, pre);
        bus(1'b0, `GPQ_PRESET_OFF, 32'h0000_0000);
        chk(rd, pre, 32'h0000_FCFC);
        for (i = 0; i < 4; i++)
            cnt[i] = ((i % 2) ? pre[7:2] : pre[15:10]) * 4 + cnt[i] % 4;
        rdpos;
        $display("Test preset done");
        // A two-code jump on the left horizontal axis flags only it
        step(1, 2);
        rdpos;
        bus(1'b0, `GPQ_STATUS_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0200, 32'h0000_0F00);
        bus(1'b1, `GPQ_STATUS_OFF, 32'h0000_0F00);
        bus(1'b0, `GPQ_STATUS_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0000, 32'h0000_0F00);
        $display("Test skip done");
        // Devices rest on arbitrary codes: no phantom step or skip
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 4; i++) cnt[i] = cnt[i] % 4;
        rdpos;
        bus(1'b0, `GPQ_STATUS_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0000, 32'h0000_0F00);
        $display("Test second reset done");
        final_report;
    end

    // Hang guard, well beyond the few thousand cycles needed
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_count++;
        final_report;
    end
endmodule

`default_nettype wire
